//--- rtl/ddeval_top.sv
// Dual-channel discrepancy evaluator with APB registers and interrupt
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Function
// (RQ1) Single channel: enable follows channel A, fault stays low.
// (RQ2) Illegal input combination or sequence raises the fault flag.
// (RQ3) Equivalent: 00 inactive, unequal discrepant, 11 active; enable only when active.
// (RQ4) Complementary: A0B1 inactive, A1B0 active, equal discrepant; enable only when active.
// (RQ5) Timer at or past limit: error state, enable low, timeout flag set.
// (RQ6) Timeout flag holds in inactive and discrepant, clears in active.
// (RQ7) Timer restarts on first change into discrepant when time is nonzero.
// (RQ8) Discrepancy time zero disables timer; timeout never raised.
// (RQ9) Active only after passing inactive since last active.
// (RQ10) Active entry only while time not expired or timing disabled.
// (RQ11) Latched timeout clears when active is reached and enable rises.
// (RQ12) Configured time must exceed the logic execution cycle.
// (RQ13) Timeout tolerance is 10 ms plus one execution cycle either way.
// (RQ14) Channels tied to one source behave as single channel evaluation.
// (RQ15) Active with enable only after the correct transition sequence.
// (RQ16) Tested sensors: time at least test gap plus off-on delay.
// (RQ17) Time is zero or 10 to 30000 ms in 10 ms steps; the 12-bit register accepts 0 to 4095 steps, up to 40950 ms.
// (RQ18) Sampling, timer and outputs advance once per execution cycle.
module ddeval_top
    import ddeval_pkg::*;
#(
    parameter int CYC_PER_MS = DDEVAL_CYC_PER_MS,
    parameter int EXEC_MS    = DDEVAL_EXEC_MS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        channel_a_input,
    input  wire logic        channel_b_input,
    output logic             enable_out,
    output logic             fault_present,
    output logic             timeout_error,
    output logic             irq
);

    localparam logic [15:0] MS_LAST   = 16'(CYC_PER_MS - 1);
    localparam logic [7:0]  EXEC_LAST = 8'(EXEC_MS - 1);
    localparam logic [15:0] EXEC_STEP = 16'(EXEC_MS);
    localparam logic [15:0] STEP_MS   = 16'(DDEVAL_DISC_STEP_MS);

    ddeval_state_t r, n;

    logic         ms_tick;
    logic         tick;
    logic         run;
    logic         tied;
    ddeval_mode_t mode;
    logic         dual;
    ddeval_st_t   cls;
    logic [15:0]  limit_ms;
    logic         timing_on;
    logic         expired;
    logic         wr_en;
    logic         setup;
    logic [2:0]   int_set;
    logic [2:0]   int_clr;
    logic [31:0]  rd_mux;
    logic         rd_err;

    always_comb begin
        ms_tick   = (r.ms_cnt == MS_LAST);
        tick      = ms_tick && (r.exec_cnt == EXEC_LAST);
        run       = r.ctrl[DDEVAL_CTRL_RUN_BIT];
        tied      = r.ctrl[DDEVAL_CTRL_TIED_BIT];
        mode      = ddeval_mode_t'(r.ctrl[DDEVAL_CTRL_MODE_LSB +: 2]);
        dual      = !tied && (mode != DDEVAL_MODE_SINGLE); // RQ14
        limit_ms  = {4'h0, r.disc} * STEP_MS;
        timing_on = (r.disc != DDEVAL_DISC_RST); // RQ8
        expired   = timing_on && (r.timer_ms >= limit_ms); // RQ13
        setup     = psel && !penable;
        wr_en     = psel && penable && pwrite;
        // Pair classification from synchronised samples
        if (mode == DDEVAL_MODE_COMPL) begin
            case ({r.s2.a, r.s2.b})
                2'b01:   cls = DDEVAL_ST_INACTIVE; // RQ4
                2'b10:   cls = DDEVAL_ST_ACTIVE; // RQ4
                default: cls = DDEVAL_ST_DISCREP; // RQ4
            endcase
        end else begin
            case ({r.s2.a, r.s2.b})
                2'b00:   cls = DDEVAL_ST_INACTIVE; // RQ3
                2'b11:   cls = DDEVAL_ST_ACTIVE; // RQ3
                default: cls = DDEVAL_ST_DISCREP; // RQ3
            endcase
        end
    end

    // Read mux, latched in the setup phase so read data comes from a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            DDEVAL_OFS_CTRL:     rd_mux[DDEVAL_CTRL_W-1:0] = r.ctrl;
            DDEVAL_OFS_DISC:     rd_mux[DDEVAL_DISC_W-1:0] = r.disc;
            DDEVAL_OFS_STATUS:   rd_mux[5:0] = {r.s2.a, r.tmo, r.fault, r.enable, r.st};
            DDEVAL_OFS_INT_STAT: rd_mux[DDEVAL_INT_W-1:0] = r.istat;
            DDEVAL_OFS_INT_MASK: rd_mux[DDEVAL_INT_W-1:0] = r.imask;
            default:             rd_err = 1'b1;
        endcase
    end

    always_comb begin
        n = r;
        // Two flops on each pin before any logic looks at it
        n.s1 = '{a: channel_a_input, b: channel_b_input};
        n.s2 = r.s1;
        n.ms_cnt = ms_tick ? 16'h0000 : r.ms_cnt + 16'h0001;
        if (ms_tick) begin
            n.exec_cnt = (r.exec_cnt == EXEC_LAST) ? 8'h00 : r.exec_cnt + 8'h01;
        end

        // Evaluation advances only on the execution tick
        if (!run) begin
            // Stopped: clean start needs inactive before active
            n.st       = DDEVAL_ST_INACTIVE;
            n.cls_d    = DDEVAL_ST_INACTIVE;
            n.timer_ms = 16'h0000;
            n.armed    = 1'b0;
            n.fault    = 1'b0;
            n.tmo      = 1'b0;
            n.enable   = 1'b0;
        end else if (tick) begin // RQ18
            n.cls_d = cls;
            if (!dual) begin
                n.enable   = r.s2.a; // RQ1 RQ14
                n.fault    = 1'b0; // RQ1
                n.tmo      = 1'b0; // RQ14
                n.timer_ms = 16'h0000;
                n.st       = r.s2.a ? DDEVAL_ST_ACTIVE : DDEVAL_ST_INACTIVE;
                n.armed    = !r.s2.a;
            end else begin
                case (cls)
                    DDEVAL_ST_INACTIVE: begin
                        n.st       = DDEVAL_ST_INACTIVE;
                        n.timer_ms = 16'h0000;
                        n.armed    = 1'b1;
                        n.fault    = 1'b0;
                        n.enable   = 1'b0; // RQ6
                    end
                    DDEVAL_ST_ACTIVE: begin
                        n.timer_ms = 16'h0000;
                        if (r.st == DDEVAL_ST_ACTIVE) begin
                            n.enable = 1'b1;
                        end else if (r.armed && !expired && r.st != DDEVAL_ST_ERROR) begin // RQ9 RQ10 RQ15
                            n.st     = DDEVAL_ST_ACTIVE;
                            n.enable = 1'b1;
                            n.tmo    = 1'b0; // RQ6 RQ11
                            n.armed  = 1'b0;
                            n.fault  = 1'b0;
                        end else begin
                            // Wrong order: held off, flagged
                            n.enable = 1'b0;
                            n.fault  = 1'b1; // RQ2
                        end
                    end
                    default: begin
                        n.enable = 1'b0;
                        if (r.st == DDEVAL_ST_ACTIVE) begin
                            n.armed = 1'b0; // RQ9
                        end
                        if (r.st == DDEVAL_ST_ERROR) begin
                            n.st = DDEVAL_ST_ERROR;
                        end else if (r.cls_d != DDEVAL_ST_DISCREP) begin
                            n.st       = DDEVAL_ST_DISCREP;
                            n.timer_ms = 16'h0000; // RQ7
                        end else if (timing_on) begin
                            n.st = DDEVAL_ST_DISCREP;
                            if (r.timer_ms <= DDEVAL_TIMER_MAX - EXEC_STEP) begin
                                n.timer_ms = r.timer_ms + EXEC_STEP; // RQ7
                            end
                        end
                        if (timing_on && r.cls_d == DDEVAL_ST_DISCREP
                                && r.timer_ms + EXEC_STEP >= limit_ms) begin
                            n.st    = DDEVAL_ST_ERROR; // RQ5
                            n.tmo   = 1'b1; // RQ5
                            n.fault = 1'b1; // RQ2
                        end
                    end
                endcase
            end
        end

        // Sticky events; a new event beats a same-cycle clear
        int_set = '0;
        int_set[DDEVAL_INT_FAULT] = n.fault && !r.fault;
        int_set[DDEVAL_INT_TMO]   = n.tmo && !r.tmo;
        int_set[DDEVAL_INT_EN]    = n.enable && !r.enable;
        int_clr = '0;
        if (wr_en && paddr == DDEVAL_OFS_INT_STAT) begin
            int_clr = pwdata[DDEVAL_INT_W-1:0];
        end
        n.istat = (r.istat & ~int_clr) | int_set;

        if (wr_en) begin
            case (paddr)
                DDEVAL_OFS_CTRL:     n.ctrl  = pwdata[DDEVAL_CTRL_W-1:0];
                DDEVAL_OFS_DISC:     n.disc  = pwdata[DDEVAL_DISC_W-1:0];
                DDEVAL_OFS_INT_MASK: n.imask = pwdata[DDEVAL_INT_W-1:0];
                default:             n.imask = r.imask;
            endcase
        end
        if (setup) begin
            n.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
            n.pslverr = rd_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.st       <= DDEVAL_ST_INACTIVE;
            r.cls_d    <= DDEVAL_ST_INACTIVE;
            r.ctrl     <= DDEVAL_CTRL_RST;
            r.disc     <= DDEVAL_DISC_RST;
            r.istat    <= DDEVAL_INT_RST;
            r.imask    <= DDEVAL_INT_RST;
        end else begin
            r <= n;
        end
    end

    // Zero wait states: the setup phase already latched the answer
    assign pready        = 1'b1;
    assign prdata        = r.prdata;
    assign pslverr       = r.pslverr && psel && penable;
    assign enable_out    = r.enable;
    assign fault_present = r.fault;
    assign timeout_error = r.tmo;
    assign irq           = |(r.istat & r.imask);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_single_follow: assert property (run && tick && !dual |=> enable_out == $past(r.s2.a)) // RQ1
        else $error("enable does not follow channel A in single mode");
    a_single_nofault: assert property (run && tick && !dual |=> !fault_present && !timeout_error) // RQ14
        else $error("fault or timeout seen in single mode");
    a_enable_state: assert property (run && dual |-> enable_out == (r.st == DDEVAL_ST_ACTIVE)) // RQ3
        else $error("enable disagrees with active state");
    a_discrep_low: assert property (run && tick && dual && cls == DDEVAL_ST_DISCREP |=> !enable_out) // RQ4
        else $error("enable high with discrepant pair");
    a_error_forces: assert property (r.st == DDEVAL_ST_ERROR |-> !enable_out && timeout_error) // RQ5
        else $error("error state without timeout flag");
    a_zero_no_tmo: assert property ($rose(timeout_error) |-> $past(r.disc) != DDEVAL_DISC_RST) // RQ8
        else $error("timeout raised with timing disabled");
    a_tmo_hold: assert property (!tick && run |=> $stable(timeout_error)) // RQ6
        else $error("timeout flag moved between ticks");
    a_arm_seq: assert property ($rose(enable_out) && dual |-> $past(r.armed) && !$past(expired)) // RQ9 RQ10
        else $error("active reached without passing inactive");
    a_tmo_clear: assert property ($rose(enable_out) |-> !timeout_error) // RQ11
        else $error("timeout not cleared on reaching active");
    a_bad_order: assert property (run && tick && dual && cls == DDEVAL_ST_ACTIVE && !r.armed
                                  && r.st != DDEVAL_ST_ACTIVE |=> fault_present && !enable_out) // RQ2
        else $error("illegal order not flagged");
    a_tick_only: assert property ($changed(enable_out) && run |-> $past(tick)) // RQ18
        else $error("enable changed off the execution tick");
    a_irq_level: assert property (irq == |(r.istat & r.imask))
        else $error("interrupt output wrong");

    // Enable, fault and timeout outputs move only on the tick while running
    a_fault_tick: assert property ($changed(fault_present) && run |-> $past(tick)) // RQ18
        else $error("fault flag changed off the execution tick");

    a_tmo_tick: assert property ($changed(timeout_error) && run |-> $past(tick)) // RQ18
        else $error("timeout flag changed off the execution tick");

    a_stop_clear: assert property (!run |=> !enable_out && !fault_present && !timeout_error) // RQ15
        else $error("outputs not cleared while stopped");

    // Clean start after stop: no arming carried over
    a_stop_armed: assert property (!run |=> !r.armed) // RQ9
        else $error("pair still armed after stop");

    a_single_state: assert property (run && tick && !dual
                                     |=> (r.st == DDEVAL_ST_ACTIVE) == $past(r.s2.a)) // RQ1
        else $error("single mode state does not follow channel A");

    a_err_entry: assert property ($rose(timeout_error) |-> r.st == DDEVAL_ST_ERROR) // RQ5
        else $error("timeout raised outside error state");

    a_err_fault: assert property (r.st == DDEVAL_ST_ERROR |-> fault_present) // RQ2
        else $error("error state without fault flag");

    a_active_tmo: assert property (r.st == DDEVAL_ST_ACTIVE |-> !timeout_error) // RQ6
        else $error("timeout flag high in active state");

    a_timer_inact: assert property (r.st == DDEVAL_ST_INACTIVE |-> r.timer_ms == 16'h0000) // RQ3
        else $error("timer running in inactive state");

    a_timer_act: assert property (r.st == DDEVAL_ST_ACTIVE |-> r.timer_ms == 16'h0000) // RQ3
        else $error("timer running in active state");

    // Sticky events must be caught on the edge they happen
    a_en_event: assert property ($rose(enable_out) |-> r.istat[DDEVAL_INT_EN])
        else $error("enable event not latched");

    a_tmo_event: assert property ($rose(timeout_error) |-> r.istat[DDEVAL_INT_TMO])
        else $error("timeout event not latched");

    a_fault_event: assert property ($rose(fault_present) |-> r.istat[DDEVAL_INT_FAULT])
        else $error("fault event not latched");

    // Zero wait states; error only inside the access phase
    a_pready_high: assert property (pready)
        else $error("ready dropped");

    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");

    c_active:  cover property ($rose(enable_out) && dual);
    c_timeout: cover property ($rose(timeout_error));
    c_bad_seq: cover property ($rose(fault_present) && !timeout_error);
    c_irq:     cover property ($rose(irq));
    c_tied:    cover property (run && tied && tick && r.s2.a);

endmodule // ddeval_top

`default_nettype wire

//--- rtl/ddeval_pkg.sv
// Package: constants, types and state record of the dual-channel discrepancy evaluator
package ddeval_pkg;

    // Register byte offsets
    localparam logic [7:0] DDEVAL_OFS_CTRL     = 8'h00;
    localparam logic [7:0] DDEVAL_OFS_DISC     = 8'h04;
    localparam logic [7:0] DDEVAL_OFS_STATUS   = 8'h08;
    localparam logic [7:0] DDEVAL_OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] DDEVAL_OFS_INT_MASK = 8'h10;

    // Control fields
    localparam int DDEVAL_CTRL_MODE_LSB = 0;
    localparam int DDEVAL_CTRL_RUN_BIT  = 2;
    localparam int DDEVAL_CTRL_TIED_BIT = 3;
    localparam int DDEVAL_CTRL_W        = 4;
    localparam int DDEVAL_DISC_W        = 12;
    localparam int DDEVAL_INT_W         = 3;

    // Interrupt bits
    localparam int DDEVAL_INT_FAULT = 0;
    localparam int DDEVAL_INT_TMO   = 1;
    localparam int DDEVAL_INT_EN    = 2;

    // Reset values
    localparam logic [3:0]  DDEVAL_CTRL_RST = 4'h0;
    localparam logic [11:0] DDEVAL_DISC_RST = 12'h000;
    localparam logic [2:0]  DDEVAL_INT_RST  = 3'h0;

    // Timing: discrepancy time counted in 10 ms steps
    localparam int DDEVAL_CLK_NS       = 100;
    localparam int DDEVAL_MS_NS        = 1000000;
    localparam int DDEVAL_CYC_PER_MS   = DDEVAL_MS_NS / DDEVAL_CLK_NS;
    localparam int DDEVAL_DISC_STEP_MS = 10;
    localparam int DDEVAL_EXEC_MS      = 4;
    localparam logic [15:0] DDEVAL_TIMER_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        DDEVAL_MODE_SINGLE = 2'h0,
        DDEVAL_MODE_EQUIV  = 2'h1,
        DDEVAL_MODE_COMPL  = 2'h2
    } ddeval_mode_t;

    // Gray along inactive -> discrepant -> active, error beside
    typedef enum logic [1:0] {
        DDEVAL_ST_INACTIVE = 2'b00,
        DDEVAL_ST_DISCREP  = 2'b01,
        DDEVAL_ST_ACTIVE   = 2'b11,
        DDEVAL_ST_ERROR    = 2'b10
    } ddeval_st_t;

    typedef struct packed {
        logic a;
        logic b;
    } ddeval_pair_t;

    typedef struct packed {
        ddeval_st_t             st;
        ddeval_st_t             cls_d;
        logic [15:0]            timer_ms;
        logic                   armed;
        logic                   fault;
        logic                   tmo;
        logic                   enable;
        ddeval_pair_t           s1;
        ddeval_pair_t           s2;
        logic [15:0]            ms_cnt;
        logic [7:0]             exec_cnt;
        logic [DDEVAL_CTRL_W-1:0] ctrl;
        logic [DDEVAL_DISC_W-1:0] disc;
        logic [DDEVAL_INT_W-1:0]  istat;
        logic [DDEVAL_INT_W-1:0]  imask;
        logic [31:0]            prdata;
        logic                   pslverr;
    } ddeval_state_t;

endpackage

//--- verification/ddeval_switch_model.sv
// Partner model: two switch contacts, channel B closing late
`timescale 1ns/100ps
`default_nettype none
module ddeval_switch_model
    import ddeval_pkg::*;
(
    input  wire logic         clk,
    input  wire ddeval_pair_t want,
    input  wire logic [4:0]   lag,
    output logic              chan_a,
    output logic              chan_b
);
    logic [4:0] cnt = 5'h0;
    initial begin
        chan_a = 1'b0;
        chan_b = 1'b0;
    end
    // Lag stands in for a tested sensor's gap and off-on delay
    always @(posedge clk) begin
        chan_a <= want.a;
        if (chan_b == want.b) begin
            cnt <= 5'h0;
        end else if (cnt >= lag) begin
            chan_b <= want.b;
            cnt    <= 5'h0;
        end else begin
            cnt <= cnt + 5'h1;
        end
    end
endmodule // ddeval_switch_model
`default_nettype wire

//--- verification/testbench.sv
// Testbench: APB master, channel scenarios and interrupt checks
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ddeval_pkg::*;
;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr  = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000, rd, prdata;
    logic         pready, pslverr, err, chan_a, chan_b, enable_out, fault_present, timeout_error, irq;
    logic         en_raw, flt_raw, tmo_raw, irq_raw;
    ddeval_pair_t want = 2'b00;
    logic [4:0]   lag  = 5'h0;
    int           error_cnt = 0, comparisons = 0;

    always #50 pclk = ~pclk;

    // Shortened counts: one evaluation tick every 8 clocks
    ddeval_top #(.CYC_PER_MS(4), .EXEC_MS(2)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .channel_a_input(chan_a), .channel_b_input(chan_b), .enable_out(en_raw),
        .fault_present(flt_raw), .timeout_error(tmo_raw), .irq(irq_raw));

    // Settled copies: never read an output in the edge that launches it
    always @(negedge pclk) begin
        enable_out    <= en_raw;
        fault_present <= flt_raw;
        timeout_error <= tmo_raw;
        irq           <= irq_raw;
    end

    ddeval_switch_model sw (.clk(pclk), .want(want), .lag(lag), .chan_a(chan_a), .chan_b(chan_b));

    task close_out;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Entered just after a rising edge; leaves one idle edge behind
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (pready !== 1'b1) begin
            error_cnt++;
            close_out;
        end
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(nm, e, rd);
    endtask

    task ticks(input int n);
        repeat (n * 8) @(posedge pclk);
    endtask

    task pair(input ddeval_pair_t p, input int n);
        want <= p;
        ticks(n);
    endtask

    task outs(input logic e, input logic f, input logic t);
        chk_bit("enable_out", e, enable_out);
        chk_bit("fault_present", f, fault_present);
        chk_bit("timeout_error", t, timeout_error);
    endtask

    // Stop, configure, settle the pair, then run
    task setup(input logic [31:0] ctrl, input logic [31:0] disc, input ddeval_pair_t p);
        apb(1'b1, DDEVAL_OFS_CTRL, 32'h0000_0000);
        apb(1'b1, DDEVAL_OFS_DISC, disc);
        pair(p, 1);
        apb(1'b1, DDEVAL_OFS_CTRL, ctrl);
        ticks(2);
    endtask

    task t_regs;
        rchk("ctrl", DDEVAL_OFS_CTRL, 32'h0000_0000);
        rchk("disc", DDEVAL_OFS_DISC, 32'h0000_0000);
        rchk("int_stat", DDEVAL_OFS_INT_STAT, 32'h0000_0000);
        rchk("int_mask", DDEVAL_OFS_INT_MASK, 32'h0000_0000);
        rchk("unmapped", 8'h14, 32'h0000_0000);
        chk_bit("pslverr", 1'b1, err);
        apb(1'b1, DDEVAL_OFS_DISC, 32'hFFFF_FFFF);
        rchk("disc", DDEVAL_OFS_DISC, 32'h0000_0FFF);
    endtask

    task t_single;
        setup(32'h0000_0004, 32'h0000_0001, 2'b00);
        pair(2'b10, 3);
        outs(1'b1, 1'b0, 1'b0);
        pair(2'b01, 3);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    // Starts already active: must pass inactive first
    task t_equiv;
        setup(32'h0000_0005, 32'h0000_0000, 2'b11);
        chk_bit("enable_out", 1'b0, enable_out);
        pair(2'b00, 2);
        outs(1'b0, 1'b0, 1'b0);
        lag <= 5'h0C;
        pair(2'b11, 4);
        outs(1'b1, 1'b0, 1'b0);
        pair(2'b10, 3);
        chk_bit("enable_out", 1'b0, enable_out);
        pair(2'b11, 3);
        outs(1'b0, 1'b1, 1'b0);
        pair(2'b00, 3);
        outs(1'b0, 1'b0, 1'b0);
        lag <= 5'h0;
    endtask

    task t_compl;
        setup(32'h0000_0006, 32'h0000_0000, 2'b01);
        pair(2'b10, 3);
        outs(1'b1, 1'b0, 1'b0);
        pair(2'b11, 3);
        chk_bit("enable_out", 1'b0, enable_out);
        pair(2'b01, 3);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    // Limit 10 ms is five ticks; allowance one step and one tick
    task t_timer;
        setup(32'h0000_0005, 32'h0000_0001, 2'b00);
        pair(2'b10, 2);
        chk_bit("timeout_error", 1'b0, timeout_error);
        ticks(8);
        outs(1'b0, 1'b1, 1'b1);
        pair(2'b11, 3);
        chk_bit("enable_out", 1'b0, enable_out);
        pair(2'b00, 3);
        outs(1'b0, 1'b0, 1'b1);
        pair(2'b11, 3);
        outs(1'b1, 1'b0, 1'b0);
        pair(2'b10, 2);
        chk_bit("timeout_error", 1'b0, timeout_error);
        ticks(8);
        chk_bit("timeout_error", 1'b1, timeout_error);
    endtask

    task t_nodisc;
        setup(32'h0000_0005, 32'h0000_0000, 2'b00);
        pair(2'b10, 20);
        outs(1'b0, 1'b0, 1'b0);
    endtask

    task t_tied;
        setup(32'h0000_000D, 32'h0000_0001, 2'b00);
        pair(2'b10, 12);
        outs(1'b1, 1'b0, 1'b0);
    endtask

    task t_irq;
        setup(32'h0000_0005, 32'h0000_0000, 2'b00);
        apb(1'b1, DDEVAL_OFS_INT_STAT, 32'h0000_0007);
        pair(2'b11, 3);
        rchk("int_stat", DDEVAL_OFS_INT_STAT, 32'h0000_0004);
        chk_bit("irq", 1'b0, irq);
        apb(1'b1, DDEVAL_OFS_INT_MASK, 32'h0000_0004);
        chk_bit("irq", 1'b1, irq);
        rchk("status", DDEVAL_OFS_STATUS, 32'h0000_0027);
        apb(1'b1, DDEVAL_OFS_STATUS, 32'h0000_0000);
        rchk("status", DDEVAL_OFS_STATUS, 32'h0000_0027);
        apb(1'b1, DDEVAL_OFS_INT_STAT, 32'h0000_0004);
        chk_bit("irq", 1'b0, irq);
        rchk("int_stat", DDEVAL_OFS_INT_STAT, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_single;
        t_equiv;
        t_compl;
        t_timer;
        t_nodisc;
        t_tied;
        t_irq;
        close_out;
    end
endmodule // testbench
`default_nettype wire
